// File: active_pointer_pkg.sv
// Constants for the dual data pointer unit: register offsets, field positions, mode codes.
// Assumes the core special-function-register port addresses registers by an 8-bit offset.
// Function
// - Two 24-bit pointers; select bit picks visible
// - Auto-swap enable inverts select after qualifying move
// - Shadow mode field: hold, increment, decrement, toggle
// - Main mode field: same encoding as shadow
// - Bit 1 absent so increment flips select
// - Bit 7 reserved, no function
// - Only pointer-addressed code/external moves trigger updates
// - All other pointer uses act on active pointer
// - Mode update first, then automatic swap
// - Control register resets to zero
package active_pointer_pkg;
  localparam logic [7:0] ADDR_POINTER_CONTROL = 8'hA7;
  localparam logic [7:0] ADDR_POINTER_LOW = 8'h82;
  localparam logic [7:0] ADDR_POINTER_HIGH = 8'h83;
  localparam logic [7:0] ADDR_POINTER_PAGE = 8'h84;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONTROL_WRITE_MASK = 8'h7D;
  localparam int BIT_SELECT = 0;
  localparam int BIT_SWAP = 6;
  localparam int MAIN_MODE_LO = 2;
  localparam int SHADOW_MODE_LO = 4;
  localparam logic [1:0] MODE_HOLD = 2'h0;
  localparam logic [1:0] MODE_INC = 2'h1;
  localparam logic [1:0] MODE_DEC = 2'h2;
  localparam logic [1:0] MODE_FLIP = 2'h3;
  localparam int MODE_BITS = 2;
  localparam int BYTE_BITS = 8;
  localparam int BYTE_LOW = 0;
  localparam int BYTE_HIGH = 1;
  localparam int BYTE_PAGE = 2;
  localparam logic [7:0] READ_IDLE = 8'h00;
endpackage

// File: active_pointer_step.sv
// Post-move update of one pointer according to its two-bit mode.
// Assumes the caller decides when the result is stored.
`timescale 1ns/1ns
`default_nettype none
module active_pointer_step
  import active_pointer_pkg::*;
#(
  parameter int WIDTH = 24
) (
  input wire logic [WIDTH-1:0] value,
  input wire logic [1:0] mode,
  output logic [WIDTH-1:0] result
);
  wire logic [WIDTH-1:0] one = {{(WIDTH-1){1'b0}}, 1'b1};
  assign result = (mode == MODE_INC) ? value + one :
                  (mode == MODE_DEC) ? value - one :
                  (mode == MODE_FLIP) ? value ^ one : value;
endmodule // active_pointer_step
`default_nettype wire

// File: dual_data_pointer_unit.sv
// Dual 24-bit data pointer register file on the core's special-function-register port.
// Assumes the core pulses move_done one cycle per pointer-addressed code or external move.
`timescale 1ns/1ns
`default_nettype none
module dual_data_pointer_unit
  import active_pointer_pkg::*;
#(
  parameter int WIDTH = 24
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic reg_write,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_hit,
  input wire logic move_done,
  input wire logic move_via_pointer,
  input wire logic pointer_load,
  input wire logic [WIDTH-1:0] pointer_load_value,
  output logic [WIDTH-1:0] active_pointer
);
  // Pointer and control storage; every register resets asynchronously.
  logic [WIDTH-1:0] main_r;
  logic [WIDTH-1:0] shadow_r;
  logic [WIDTH-1:0] main_nxt;
  logic [WIDTH-1:0] shadow_nxt;
  logic [7:0] control_r;
  logic [7:0] control_nxt;
  logic [WIDTH-1:0] main_step;
  logic [WIDTH-1:0] shadow_step;

  // Address compare shared by the write strobes, the hit flag and the read mux.
  function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
    return addr == offset;
  endfunction

  // One byte lane of a pointer, lane 0 being the least significant.
  function automatic logic [7:0] get_byte(input logic [WIDTH-1:0] v, input int idx);
    return v[idx*BYTE_BITS +: BYTE_BITS];
  endfunction

  function automatic logic [WIDTH-1:0] put_byte(input logic [WIDTH-1:0] v,
                                                input logic [7:0] b,
                                                input int idx);
    logic [WIDTH-1:0] r;
    r = v;
    r[idx*BYTE_BITS +: BYTE_BITS] = b;
    return r;
  endfunction

  // A lane is replaced only while its own write strobe is high.
  function automatic logic [WIDTH-1:0] lane_write(input logic [WIDTH-1:0] v,
                                                  input logic en,
                                                  input logic [7:0] b,
                                                  input int idx);
    return en ? put_byte(v, b, idx) : v;
  endfunction

  wire logic hit_ctrl = hits(reg_addr, ADDR_POINTER_CONTROL);
  wire logic hit_low = hits(reg_addr, ADDR_POINTER_LOW);
  wire logic hit_high = hits(reg_addr, ADDR_POINTER_HIGH);
  wire logic hit_page = hits(reg_addr, ADDR_POINTER_PAGE);
  wire logic wr_ctrl = reg_write & hit_ctrl;
  wire logic wr_low = reg_write & hit_low;
  wire logic wr_high = reg_write & hit_high;
  wire logic wr_page = reg_write & hit_page;

  wire logic sel = control_r[BIT_SELECT];
  wire logic swap_on = control_r[BIT_SWAP];
  wire logic [1:0] main_mode = control_r[MAIN_MODE_LO +: MODE_BITS];
  wire logic [1:0] shadow_mode = control_r[SHADOW_MODE_LO +: MODE_BITS];

  // Moves through the program counter or a working register leave both pointers alone.
  wire logic qualify = move_done & move_via_pointer;
  // A control write in the same cycle wins, so software never loses its own select value.
  wire logic swap_now = qualify & swap_on & ~wr_ctrl;

  assign active_pointer = sel ? shadow_r : main_r;

  active_pointer_step #(.WIDTH(WIDTH)) u_main_step (
    .value(main_r),
    .mode(main_mode),
    .result(main_step)
  );
  active_pointer_step #(.WIDTH(WIDTH)) u_shadow_step (
    .value(shadow_r),
    .mode(shadow_mode),
    .result(shadow_step)
  );

  // Only the active pointer steps, and it steps from its value before the swap.
  wire logic [WIDTH-1:0] moved = sel ? shadow_step : main_step;
  wire logic [WIDTH-1:0] loaded = pointer_load ? pointer_load_value : active_pointer;
  wire logic [WIDTH-1:0] base = (qualify & ~pointer_load) ? moved : loaded;
  // Byte writes land last, on top of a load or a step in the same cycle.
  wire logic [WIDTH-1:0] lane0 = lane_write(base, wr_low, reg_wdata, BYTE_LOW);
  wire logic [WIDTH-1:0] lane1 = lane_write(lane0, wr_high, reg_wdata, BYTE_HIGH);
  wire logic [WIDTH-1:0] lane2 = lane_write(lane1, wr_page, reg_wdata, BYTE_PAGE);

  // The idle pointer is never written, which keeps a byte write from leaking across.
  assign main_nxt = sel ? main_r : lane2;
  assign shadow_nxt = sel ? lane2 : shadow_r;

  // Bits 1 and 7 are masked so an increment of the register only flips the select.
  wire logic [7:0] control_written = reg_wdata & CONTROL_WRITE_MASK;

  always_comb begin
    control_nxt = control_r;
    if (wr_ctrl) begin
      control_nxt = control_written;
    end else if (swap_now) begin
      control_nxt[BIT_SELECT] = ~sel;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      control_r <= CONTROL_RESET;
    end else begin
      control_r <= control_nxt;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      main_r <= '0;
    end else begin
      main_r <= main_nxt;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      shadow_r <= '0;
    end else begin
      shadow_r <= shadow_nxt;
    end
  end

  wire logic [7:0] rd_low = get_byte(active_pointer, BYTE_LOW);
  wire logic [7:0] rd_high = get_byte(active_pointer, BYTE_HIGH);
  wire logic [7:0] rd_page = get_byte(active_pointer, BYTE_PAGE);

  assign reg_hit = hit_ctrl | hit_low | hit_high | hit_page;
  // Unmapped offsets read as zero so the core's read mux can merge this freely.
  assign reg_rdata = hit_ctrl ? control_r :
                     hit_low ? rd_low :
                     hit_high ? rd_high :
                     hit_page ? rd_page : READ_IDLE;
endmodule // dual_data_pointer_unit
`default_nettype wire

// File: core_model.sv
// Core-side model that issues one code or external-data move per call.
// Assumes the unit samples move_done on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module core_model (
  input wire logic clock,
  output var logic move_done,
  output var logic move_via_pointer
);
  initial {move_done, move_via_pointer} = 2'b00;
  task automatic move(input logic via, input int gap);
    repeat (gap) @(negedge clock);
    {move_done, move_via_pointer} = {1'b1, via};
    @(negedge clock) {move_done, move_via_pointer} = {1'b0, ~via};
  endtask
endmodule // core_model
`default_nettype wire

// File: ptr_chk_asserts.sv
// Port checker for the dual pointer unit.
// Assumes reg_addr rests on the control register while moves run.
`timescale 1ns/1ns
`default_nettype none
module ptr_chk
  import active_pointer_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic reg_write,
  input wire logic move_done,
  input wire logic move_via_pointer,
  input wire logic pointer_load,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [23:0] pointer_load_value,
  input wire logic [23:0] active_pointer
);
  wire logic c = reg_addr == ADDR_POINTER_CONTROL;
  wire logic v = c && move_done && move_via_pointer && !reg_write && !pointer_load;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  property p_wr;
    reg_write && c |=> !c || reg_rdata == ($past(reg_wdata) & CONTROL_WRITE_MASK);
  endproperty
  a_wr: assert property (p_wr) else $error("control write");
  property p_rs; c |-> reg_rdata[7] == 1'b0 && reg_rdata[1] == 1'b0; endproperty
  a_rs: assert property (p_rs) else $error("unused control bit");
  property p_ig;
    move_done && !move_via_pointer && !reg_write && !pointer_load |=> $stable(active_pointer);
  endproperty
  a_ig: assert property (p_ig) else $error("ignored move");
  property p_ld; pointer_load && !reg_write && !move_done |=>
    active_pointer == $past(pointer_load_value); endproperty
  a_ld: assert property (p_ld) else $error("load");
  property p_pg; reg_addr == ADDR_POINTER_PAGE |-> reg_rdata == active_pointer[23:16]; endproperty
  a_pg: assert property (p_pg) else $error("page byte");
  property p_sw; v ##1 c |-> reg_rdata[0] == ($past(reg_rdata[0]) ^ $past(reg_rdata[6])); endproperty
  a_sw: assert property (p_sw) else $error("swap");
  property p_in; v && reg_rdata[6:0] == 7'h04 |=> active_pointer == $past(active_pointer) + 24'h000001; endproperty
  a_in: assert property (p_in) else $error("increment");
  property p_dc; v && reg_rdata[6:0] == 7'h21 |=> active_pointer == $past(active_pointer) - 24'h000001; endproperty
  a_dc: assert property (p_dc) else $error("decrement");
  cover property (v && reg_rdata[6]);
  cover property (pointer_load);
  cover property (move_done && !move_via_pointer);
endmodule // ptr_chk
bind dual_data_pointer_unit ptr_chk ptr_chk_i (
  .clock(clock),
  .sys_rst(sys_rst),
  .reg_write(reg_write),
  .move_done(move_done),
  .move_via_pointer(move_via_pointer),
  .pointer_load(pointer_load),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata),
  .pointer_load_value(pointer_load_value),
  .active_pointer(active_pointer)
);
`default_nettype wire

// File: dual_data_pointer_unit_tb.sv
// Bench for the pointer unit: registers and loads from here, moves from the core model.
// Assumes results settle 5 ns after the rising edge.
`timescale 1ns/1ns
`default_nettype none
module dual_data_pointer_unit_tb;
  import active_pointer_pkg::*;
  logic clock = 1'b0, sys_rst = 1'b1, reg_write = 1'b0, pointer_load = 1'b0, rd_probe = 1'b0;
  logic reg_hit, move_done, move_via_pointer;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic [23:0] pointer_load_value = 24'h000000, active_pointer, p [2], q [$];
  logic [23:0] dlt [4] = '{24'hFFFFFF, 24'h000000, 24'h000000, 24'h000001};
  logic [8:0] rq [$];
  int errors = 0, checks_done = 0, cyc = 0, s;
  dual_data_pointer_unit dual_data_pointer_unit_i (
    .clock(clock),
    .sys_rst(sys_rst),
    .reg_addr(reg_addr),
    .reg_write(reg_write),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_hit(reg_hit),
    .move_done(move_done),
    .move_via_pointer(move_via_pointer),
    .pointer_load(pointer_load),
    .pointer_load_value(pointer_load_value),
    .active_pointer(active_pointer)
  );
  core_model core_model_i (
    .clock(clock),
    .move_done(move_done),
    .move_via_pointer(move_via_pointer)
  );
  initial forever #20 clock = ~clock;
  always @(posedge clock) if (++cyc > 300) begin errors++; results(); end
  // Every write, load or move yields exactly one note, so the queue stays in step.
  always @(posedge clock) if (reg_write || pointer_load || move_done) begin
    #5 check(q.pop_front());
  end
  // A read cycle carries no strobe, so the state still stands 5 ns after the edge.
  always @(posedge clock) if (rd_probe) begin
    #5 check_rd(rq.pop_front());
  end
  task check(input logic [23:0] e);
    checks_done++;
    if (active_pointer !== e) begin errors++; $display("[FAIL] %0t pointer mismatch", $time); end
  endtask
  task check_rd(input logic [8:0] e);
    checks_done++;
    if ({reg_hit, reg_rdata} !== e) begin
      errors++;
      $display("[FAIL] %0t register read mismatch", $time);
    end
  endtask
  task rd(input logic [7:0] ad, input logic [8:0] e);
    {reg_addr, reg_write, pointer_load, rd_probe} = {ad, 1'b0, 1'b0, 1'b1};
    rq.push_back(e);
    @(negedge clock);
  endtask
  task op(input logic [1:0] k, input logic [7:0] ad, input logic [7:0] d, input logic [23:0] e);
    {reg_addr, reg_wdata, reg_write, pointer_load, rd_probe} = {ad, d, k == 2'h0, k == 2'h1, 1'b0};
    pointer_load_value = e;
    q.push_back(e);
    if (k[1]) core_model_i.move(!k[0], int'(k[0]));
    else @(negedge clock);
  endtask
  initial begin
    void'($urandom(32'hAF1218C8));
    repeat (5) @(negedge clock);
    sys_rst = 1'b0;
    p = '{24'h000000, 24'($urandom)};
    rd(ADDR_POINTER_CONTROL, {1'b1, CONTROL_RESET});
    rd(8'h00, {1'b0, READ_IDLE});
    op(2'h1, 8'h00, 8'h00, p[0]);
    op(2'h0, ADDR_POINTER_CONTROL, 8'h01, 24'h000000);
    op(2'h1, 8'h00, 8'h00, p[1]);
    p[1][23:16] = 8'hA5;
    op(2'h0, ADDR_POINTER_PAGE, 8'hA5, p[1]);
    rd(ADDR_POINTER_PAGE, {1'b1, 8'hA5});
    rd(ADDR_POINTER_HIGH, {1'b1, p[1][15:8]});
    rd(ADDR_POINTER_LOW, {1'b1, p[1][7:0]});
    for (int i = 0; i < 8; i++) begin
      s = i / 4;
      op(2'h0, 8'hA7, s ? {2'h0, i[1:0] ^ 2'h2, 4'h1} : {4'h0, i[1:0] ^ 2'h2, 2'h0}, p[s]);
      p[s] = (i % 4 == 1) ? p[s] ^ 24'h000001 : p[s] + dlt[i % 4];
      op(2'h2, 8'hA7, 8'h00, p[s]);
    end
    op(2'h3, 8'hA7, 8'h00, p[1]);
    op(2'h0, 8'hA7, 8'h55, p[1]);
    p[1] = p[1] + 24'h000001;
    op(2'h2, 8'hA7, 8'h00, p[0]);
    op(2'h0, 8'hA7, 8'hD6, p[0]);
    rd(8'hA7, {1'b1, 8'h54});
    op(2'h0, 8'hA7, 8'h55, p[1]);
    {reg_write, pointer_load, rd_probe, sys_rst} = 4'b0001;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    rd(8'hA7, {1'b1, CONTROL_RESET});
    rd(ADDR_POINTER_LOW, {1'b1, 8'h00});
    {reg_write, pointer_load, rd_probe} = 3'b000;
    @(negedge clock);
    results();
  end
  task results();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
endmodule // dual_data_pointer_unit_tb
`default_nettype wire
